// ---- wdt_pkg.sv ----
// Purpose: Shared constants and types for the watchdog/interval timer.
// Assumes: 200 MHz clk_sys and byte-addressed internal bus.
// Notes: How it works is summarised below.
// How it works
// RULE_01: Byte reads: control B8, counter B9, reset-control BB.
// RULE_02: Watchdog mode when mode select and enable.
// RULE_03: Software reloads counter before it overflows.
// RULE_04: Watchdog overflow drives output low 128 cycles.
// RULE_05: Reset enable gives 512-cycle chip reset, kind selectable.
// RULE_06: Pin reset wins and clears watchdog flag.
// RULE_07: Interval mode overflow requests timer interrupt.
// RULE_08: Interval overflow sets interval flag with interrupt.
// RULE_09: Watchdog overflow sets watchdog flag with output.
// RULE_10: Standby refused while timer enable is set.
// RULE_11: Software picks interval covering oscillator settling.
// RULE_12: NMI in standby counts; wrap ends standby.
// RULE_13: Counter write beats coincident count pulse.
// RULE_14: Stop timer before changing prescaler select.
// RULE_15: Stop timer before switching timer mode.
// RULE_16: Never loop overflow output into own reset.
// RULE_17: Without reset enable, overflow clears counter and control.
// RULE_18: Keyed word writes: 5A counter, A5 control.
// RULE_19: Reset-control keys: A5 clears flag, 5A configures.
// RULE_20: Prescaler selects divide 2 through 8192.
// RULE_21: Disabled timer holds counter at zero.
// RULE_22: Counter increments per prescaled pulse, wraps FF.
package wdt_pkg;
  localparam int ADDR_WIDTH = 28;
  localparam logic [27:0] ADDR_CTRL = 28'h5ffffb8;
  localparam logic [27:0] ADDR_COUNTER_RD = 28'h5ffffb9;
  localparam logic [27:0] ADDR_RSTCTRL_WR = 28'h5ffffba;
  localparam logic [27:0] ADDR_RSTCTRL_RD = 28'h5ffffbb;
  localparam logic [7:0] KEY_COUNTER = 8'h5a;
  localparam logic [7:0] KEY_CONTROL = 8'ha5;
  localparam logic [7:0] RCTL_CLEAR_DATA = 8'h00;
  localparam logic [7:0] COUNTER_RESET = 8'h00;
  localparam logic [7:0] COUNTER_MAX = 8'hff;
  localparam logic [7:0] CTRL_RESERVED = 8'h18;
  localparam logic [7:0] RCTL_RESERVED = 8'h1f;
  localparam logic [2:0] PRESC_RESET = 3'h0;
  localparam int CTRL_OVF_BIT = 7;
  localparam int CTRL_MODE_BIT = 6;
  localparam int CTRL_TME_BIT = 5;
  localparam int RCTL_WATCHDOG_OVERFLOW_FLAG_BIT = 7;
  localparam int RCTL_CHIP_RST_ON_OVERFLOW_EN_BIT = 6;
  localparam int RCTL_RST_KIND_SELECT_BIT = 5;
  localparam int OVF_PULSE_CYCLES = 128;
  localparam int CHIP_RST_CYCLES = 512;
  localparam int PRESC_WIDTH = 13;
  // Divide ratio as a power of two, per select code
  localparam logic [3:0] PRESC_EXP [0:7] = '{4'h1, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hc, 4'hd};
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_STANDBY = 3'b010,
    ST_WAKE = 3'b100
  } wdt_standby_t;
endpackage : wdt_pkg

// ---- wdt_presc_if.sv ----
// Purpose: Carries run, select and tick between timer and prescaler.
// Assumes: Single clk_sys domain.
// Notes: Tick is a one-cycle pulse.
`timescale 1ns/10ps
interface wdt_presc_if;
  logic run;
  logic [2:0] sel;
  logic tick;
  modport ctrl (output run, output sel, input tick);
  modport presc (input run, input sel, output tick);
endinterface : wdt_presc_if

// ---- wdt_prescaler.sv ----
// Purpose: Divides clk_sys into the selected count pulse.
// Assumes: Select is stable while running.
// Notes: Divider clears while stopped so intervals start clean.
`timescale 1ns/10ps
module wdt_prescaler (
  input wire logic clk_sys,
  input wire logic srst,
  wdt_presc_if.presc pif
);
  logic [wdt_pkg::PRESC_WIDTH-1:0] divCount;
  logic [wdt_pkg::PRESC_WIDTH-1:0] divMask;

  // RULE_20: ratio from select
  assign divMask = wdt_pkg::PRESC_WIDTH'((14'h1 << wdt_pkg::PRESC_EXP[pif.sel]) - 14'h1);
  assign pif.tick = pif.run && ((divCount & divMask) == divMask);

  // Free divider, held at zero when stopped
  always_ff @(posedge clk_sys) begin
    if (srst || !pif.run) begin
      divCount <= '0;
    end else begin
      divCount <= divCount + 1'b1;
    end
  end
endmodule : wdt_prescaler

// ---- wdt_pulse_timer.sv ----
// Purpose: Stretches a start pulse into a level of fixed length.
// Assumes: Start is a one-cycle pulse on clk_sys.
// Notes: A start while active is ignored.
`timescale 1ns/10ps
module wdt_pulse_timer #(
  parameter int CYCLES = 128
) (
  input wire logic clk_sys,
  input wire logic clear,
  input wire logic start,
  output logic active
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] remain;

  // Active for exactly CYCLES cycles after start
  always_ff @(posedge clk_sys) begin
    if (clear) begin
      active <= 1'b0;
      remain <= '0;
    end else if (!active && start) begin
      active <= 1'b1;
      remain <= CW'(CYCLES - 1);
    end else if (active) begin
      if (remain == '0) begin
        active <= 1'b0;
      end else begin
        remain <= remain - 1'b1;
      end
    end
  end
endmodule : wdt_pulse_timer

// ---- wdt_watchdog_unit.sv ----
// Purpose: Eight-bit watchdog / interval timer with keyed registers.
// Assumes: Bus write strobe marks the final bus state of a write.
// Notes: Read data arrives one cycle after the read strobe.
`timescale 1ns/10ps
module wdt_watchdog_unit (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic hwRstPinN,
  input wire logic [27:0] busAddr,
  input wire logic busWrite,
  input wire logic busRead,
  input wire logic busWordAccess,
  input wire logic [15:0] busWdata,
  output logic [7:0] busRdata,
  output logic busRvalid,
  input wire logic standbyReq,
  input wire logic nmiReq,
  output logic overflowOutN,
  output logic chipRstOut,
  output logic chipRstManual,
  output logic intervalTimerIrq,
  output logic standbyActive,
  output logic standbyRefused,
  output logic chipClockEn
);
  // Pin reset synchroniser
  logic pinMeta;
  logic pinSync;
  logic pinRst;
  logic unitRst;

  // Register state
  logic [7:0] counter;
  logic intervalOverflowFlag;
  logic watchdogModeSelect;
  logic timerEnableBit;
  logic [2:0] prescaleSelect;
  logic watchdogOverflowFlag;
  logic chipRstOnOverflowEn;
  logic rstKindSelect;

  // Decode and events
  logic wordWr;
  logic [7:0] wrKey;
  logic [7:0] wrData;
  logic counterWr;
  logic controlWr;
  logic flagClearWr;
  logic rstCfgWr;
  logic countRun;
  logic overflow;
  logic wdOverflow;
  logic itOverflow;
  logic wakeOverflow;
  logic standbyEnter;
  logic ovfPulseActive;
  logic chipRstActive;
  logic [7:0] controlView;
  logic [7:0] rstCtrlView;

  wdt_pkg::wdt_standby_t stbState;
  wdt_pkg::wdt_standby_t next_stbState;

  wdt_presc_if pif ();

  // Pin level passes two flops before use
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      pinMeta <= 1'b1;
      pinSync <= 1'b1;
    end else begin
      pinMeta <= hwRstPinN;
      pinSync <= pinMeta;
    end
  end

  assign pinRst = !pinSync;
  assign unitRst = srst || pinRst;

  // RULE_18: keyed word writes only
  assign wordWr = busWrite && busWordAccess;
  assign wrKey = busWdata[15:8];
  assign wrData = busWdata[7:0];
  assign counterWr = wordWr && (busAddr == wdt_pkg::ADDR_CTRL) && (wrKey == wdt_pkg::KEY_COUNTER);
  assign controlWr = wordWr && (busAddr == wdt_pkg::ADDR_CTRL) && (wrKey == wdt_pkg::KEY_CONTROL);

  // RULE_19: reset-control key split
  assign flagClearWr = wordWr && (busAddr == wdt_pkg::ADDR_RSTCTRL_WR) && (wrKey == wdt_pkg::KEY_CONTROL)
                       && (wrData == wdt_pkg::RCTL_CLEAR_DATA);
  assign rstCfgWr = wordWr && (busAddr == wdt_pkg::ADDR_RSTCTRL_WR) && (wrKey == wdt_pkg::KEY_COUNTER);

  // RULE_12: wake phase counts with enable clear
  assign countRun = timerEnableBit || (stbState == wdt_pkg::ST_WAKE);

  assign pif.run = countRun;
  assign pif.sel = prescaleSelect;

  wdt_prescaler u_presc (
    .clk_sys(clk_sys),
    .srst(unitRst),
    .pif(pif)
  );

  // RULE_13: write suppresses coincident wrap
  assign overflow = countRun && pif.tick && (counter == wdt_pkg::COUNTER_MAX) && !counterWr;
  // RULE_02: watchdog mode decode
  assign wdOverflow = overflow && watchdogModeSelect && timerEnableBit;
  // RULE_07: interval mode decode
  assign itOverflow = overflow && !watchdogModeSelect && timerEnableBit;
  assign wakeOverflow = overflow && (stbState == wdt_pkg::ST_WAKE);

  // RULE_22: count up on each tick
  always_ff @(posedge clk_sys) begin
    if (unitRst || wdOverflow) begin
      counter <= wdt_pkg::COUNTER_RESET;
    end else if (!countRun) begin
      // RULE_21: held at zero
      counter <= wdt_pkg::COUNTER_RESET;
    end else if (counterWr) begin
      counter <= wrData;
    end else if (pif.tick) begin
      counter <= counter + 8'h01;
    end
  end

  // RULE_17: overflow reinitialises control state
  always_ff @(posedge clk_sys) begin
    if (unitRst || wdOverflow) begin
      watchdogModeSelect <= 1'b0;
      timerEnableBit <= 1'b0;
      prescaleSelect <= wdt_pkg::PRESC_RESET;
    end else if (controlWr) begin
      watchdogModeSelect <= wrData[wdt_pkg::CTRL_MODE_BIT];
      timerEnableBit <= wrData[wdt_pkg::CTRL_TME_BIT];
      prescaleSelect <= wrData[2:0];
    end
  end

  // RULE_08: interval flag, set beats clear
  always_ff @(posedge clk_sys) begin
    if (unitRst || wdOverflow) begin
      intervalOverflowFlag <= 1'b0;
    end else if (itOverflow) begin
      intervalOverflowFlag <= 1'b1;
    end else if (controlWr && !wrData[wdt_pkg::CTRL_OVF_BIT]) begin
      intervalOverflowFlag <= 1'b0;
    end
  end

  // RULE_07: level request while flag set
  assign intervalTimerIrq = intervalOverflowFlag;

  // RULE_06: pin reset clears watchdog flag
  always_ff @(posedge clk_sys) begin
    if (unitRst || standbyEnter) begin
      watchdogOverflowFlag <= 1'b0;
    end else if (wdOverflow) begin
      // RULE_09: flag with overflow output
      watchdogOverflowFlag <= 1'b1;
    end else if (flagClearWr) begin
      watchdogOverflowFlag <= 1'b0;
    end
  end

  // Reset options survive the watchdog's own reset
  always_ff @(posedge clk_sys) begin
    if (unitRst || standbyEnter) begin
      chipRstOnOverflowEn <= 1'b0;
      rstKindSelect <= 1'b0;
    end else if (rstCfgWr) begin
      chipRstOnOverflowEn <= wrData[wdt_pkg::RCTL_CHIP_RST_ON_OVERFLOW_EN_BIT];
      rstKindSelect <= wrData[wdt_pkg::RCTL_RST_KIND_SELECT_BIT];
    end
  end

  // RULE_04: 128-cycle overflow output
  wdt_pulse_timer #(
    .CYCLES(wdt_pkg::OVF_PULSE_CYCLES)
  ) u_ovf_pulse (
    .clk_sys(clk_sys),
    .clear(unitRst),
    .start(wdOverflow),
    .active(ovfPulseActive)
  );

  // RULE_05: 512-cycle chip reset when enabled
  wdt_pulse_timer #(
    .CYCLES(wdt_pkg::CHIP_RST_CYCLES)
  ) u_chip_rst (
    .clk_sys(clk_sys),
    .clear(unitRst),
    .start(wdOverflow && chipRstOnOverflowEn),
    .active(chipRstActive)
  );

  assign overflowOutN = !ovfPulseActive;
  assign chipRstOut = chipRstActive;

  // Kind is frozen at the overflow so a later write cannot change it
  always_ff @(posedge clk_sys) begin
    if (unitRst) begin
      chipRstManual <= 1'b0;
    end else if (wdOverflow && chipRstOnOverflowEn && !chipRstActive) begin
      chipRstManual <= rstKindSelect;
    end
  end

  // RULE_10: standby only with timer stopped
  assign standbyEnter = (stbState == wdt_pkg::ST_RUN) && standbyReq && !timerEnableBit;

  // Standby sequencing
  always_comb begin
    next_stbState = stbState;
    case (stbState)
      wdt_pkg::ST_RUN: begin
        if (standbyEnter) begin
          next_stbState = wdt_pkg::ST_STANDBY;
        end
      end
      wdt_pkg::ST_STANDBY: begin
        if (nmiReq) begin
          next_stbState = wdt_pkg::ST_WAKE;
        end
      end
      wdt_pkg::ST_WAKE: begin
        // RULE_12: wrap ends standby
        if (wakeOverflow) begin
          next_stbState = wdt_pkg::ST_RUN;
        end
      end
      default: begin
        next_stbState = wdt_pkg::ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (unitRst) begin
      stbState <= wdt_pkg::ST_RUN;
    end else begin
      stbState <= next_stbState;
    end
  end

  // RULE_10: refusal reported as a pulse
  always_ff @(posedge clk_sys) begin
    if (unitRst) begin
      standbyRefused <= 1'b0;
    end else begin
      standbyRefused <= (stbState == wdt_pkg::ST_RUN) && standbyReq && timerEnableBit;
    end
  end

  assign standbyActive = (stbState != wdt_pkg::ST_RUN);
  assign chipClockEn = (stbState == wdt_pkg::ST_RUN);

  // Read views; reserved bits read as one
  always_comb begin
    controlView = wdt_pkg::CTRL_RESERVED;
    controlView[wdt_pkg::CTRL_OVF_BIT] = intervalOverflowFlag;
    controlView[wdt_pkg::CTRL_MODE_BIT] = watchdogModeSelect;
    controlView[wdt_pkg::CTRL_TME_BIT] = timerEnableBit;
    controlView[2:0] = prescaleSelect;
    rstCtrlView = wdt_pkg::RCTL_RESERVED;
    rstCtrlView[wdt_pkg::RCTL_WATCHDOG_OVERFLOW_FLAG_BIT] = watchdogOverflowFlag;
    rstCtrlView[wdt_pkg::RCTL_CHIP_RST_ON_OVERFLOW_EN_BIT] = chipRstOnOverflowEn;
    rstCtrlView[wdt_pkg::RCTL_RST_KIND_SELECT_BIT] = rstKindSelect;
  end

  // RULE_01: byte reads at three addresses
  always_ff @(posedge clk_sys) begin
    if (unitRst) begin
      busRdata <= 8'h00;
      busRvalid <= 1'b0;
    end else begin
      busRvalid <= busRead && !busWordAccess;
      if (busRead && !busWordAccess) begin
        case (busAddr)
          wdt_pkg::ADDR_CTRL: busRdata <= controlView;
          wdt_pkg::ADDR_COUNTER_RD: busRdata <= counter;
          wdt_pkg::ADDR_RSTCTRL_RD: busRdata <= rstCtrlView;
          default: busRdata <= 8'h00;
        endcase
      end
    end
  end
endmodule : wdt_watchdog_unit

// ---- wdt_props.sv ----
// Purpose: Port-level checks for the watchdog unit.
// Assumes: Single clk_sys domain, srst sync high.
// Notes: Pin reset during a pulse is not covered.
`timescale 1ns/10ps
module wdt_props (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic busRead,
  input wire logic busWordAccess,
  input wire logic busRvalid,
  input wire logic standbyReq,
  input wire logic overflowOutN,
  input wire logic chipRstOut,
  input wire logic standbyActive,
  input wire logic standbyRefused,
  input wire logic chipClockEn
);
  logic [7:0] lowCnt;
  logic [9:0] rstCnt;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  // Run lengths, since repetition counts this long are too slow
  always_ff @(posedge clk_sys) begin
    lowCnt <= overflowOutN ? 8'h00 : lowCnt + 8'h01;
  end
  always_ff @(posedge clk_sys) begin
    rstCnt <= chipRstOut ? rstCnt + 10'h001 : 10'h000;
  end
  // Pulse lengths, bus answer and standby handling
  ovf_len_a: assert property ($rose(overflowOutN) |-> lowCnt == 8'h80) else $error("bad low length");
  ovf_cap_a: assert property (!overflowOutN |-> lowCnt < 8'h80) else $error("low too long");
  rst_len_a: assert property ($fell(chipRstOut) |-> rstCnt == 10'h200) else $error("bad reset length");
  rst_cap_a: assert property (chipRstOut |-> rstCnt < 10'h200) else $error("reset too long");
  rst_with_ovf_a: assert property ($rose(chipRstOut) |-> $fell(overflowOutN)) else $error("reset not aligned");
  rd_answer_a: assert property (busRead && !busWordAccess |=> busRvalid) else $error("read unanswered");
  rd_only_a: assert property (busRvalid |-> $past(busRead) && !$past(busWordAccess)) else $error("stray valid");
  refuse_ok_a: assert property (standbyRefused |-> $past(standbyReq) && !standbyActive) else $error("bad refuse");
  sleep_clk_a: assert property (standbyActive |-> !chipClockEn) else $error("clock on in standby");
  wake_clk_a: assert property ($fell(standbyActive) |-> chipClockEn) else $error("clock off after wake");
  cover property ($rose(chipRstOut));
  cover property ($fell(standbyActive));
  cover property (standbyRefused);
endmodule : wdt_props
bind wdt_watchdog_unit wdt_props u_props (.clk_sys(clk_sys), .srst(srst), .busRead(busRead),
  .busWordAccess(busWordAccess), .busRvalid(busRvalid), .standbyReq(standbyReq), .overflowOutN(overflowOutN),
  .chipRstOut(chipRstOut), .standbyActive(standbyActive), .standbyRefused(standbyRefused), .chipClockEn(chipClockEn));

// ---- wdt_cpu_model.sv ----
// Purpose: CPU bus master and external reset circuit.
// Assumes: Strobes are one-cycle pulses on clk_sys.
// Notes: Released address and data are inverted, not held.
`timescale 1ns/10ps
module wdt_cpu_model (
  input wire logic clk_sys,
  input wire logic [7:0] busRdata,
  input wire logic busRvalid,
  output logic [27:0] busAddr,
  output logic busWrite,
  output logic busRead,
  output logic busWordAccess,
  output logic [15:0] busWdata,
  output logic hwRstPinN
);
  // Idle bus at time zero
  initial begin
    busAddr = 28'h0000000;
    busWrite = 1'b0;
    busRead = 1'b0;
    busWordAccess = 1'b0;
    busWdata = 16'h0000;
    hwRstPinN = 1'b1;
  end
  task automatic wr(input logic [7:0] a, input logic [15:0] w, input logic word);
    @(posedge clk_sys);
    busAddr <= {20'h5ffff, a};
    busWdata <= w;
    busWordAccess <= word;
    busWrite <= 1'b1;
    @(posedge clk_sys);
    busWrite <= 1'b0;
    busAddr <= ~{20'h5ffff, a};
    busWdata <= ~w;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(posedge clk_sys);
    busAddr <= {20'h5ffff, a};
    busWordAccess <= 1'b0;
    busRead <= 1'b1;
    @(posedge clk_sys);
    busRead <= 1'b0;
    busAddr <= ~{20'h5ffff, a};
    q = 8'hxx;
    for (int i = 0; i < 4; i++) begin
      #1;
      if (busRvalid === 1'b1) begin
        q = busRdata;
        break;
      end
      @(posedge clk_sys);
    end
  endtask : rd
  // own reset circuit, never fed from the overflow pin
  task automatic pin_rst();
    @(posedge clk_sys);
    hwRstPinN <= 1'b0;
    repeat (4) @(posedge clk_sys);
    hwRstPinN <= 1'b1;
    repeat (4) @(posedge clk_sys);
  endtask : pin_rst
endmodule : wdt_cpu_model

// ---- tb.sv ----
// Purpose: Register-level tests of the watchdog unit.
// Assumes: 200 MHz clk_sys, srst held 2 cycles.
// Notes: Counter preloads keep overflow waits short.
`timescale 1ns/10ps
module tb;
  logic clk_sys, srst, hwRstPinN, standbyReq, nmiReq, busWrite, busRead, busWordAccess, busRvalid;
  logic [27:0] busAddr;
  logic [15:0] busWdata;
  logic [7:0] busRdata, d;
  logic overflowOutN, chipRstOut, chipRstManual, intervalTimerIrq, standbyActive, standbyRefused, chipClockEn;
  int n_fail = 0;
  int checks = 0;
  wdt_cpu_model u_cpu (.clk_sys(clk_sys), .busRdata(busRdata), .busRvalid(busRvalid), .busAddr(busAddr),
    .busWrite(busWrite), .busRead(busRead), .busWordAccess(busWordAccess), .busWdata(busWdata), .hwRstPinN(hwRstPinN));
  wdt_watchdog_unit DUT (.clk_sys(clk_sys), .srst(srst), .hwRstPinN(hwRstPinN), .busAddr(busAddr),
    .busWrite(busWrite), .busRead(busRead), .busWordAccess(busWordAccess), .busWdata(busWdata),
    .busRdata(busRdata), .busRvalid(busRvalid), .standbyReq(standbyReq), .nmiReq(nmiReq),
    .overflowOutN(overflowOutN), .chipRstOut(chipRstOut), .chipRstManual(chipRstManual),
    .intervalTimerIrq(intervalTimerIrq), .standbyActive(standbyActive), .standbyRefused(standbyRefused),
    .chipClockEn(chipClockEn));
  task close_out();
    if (n_fail == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task rchk(input logic [7:0] a, input logic [7:0] exp);
    u_cpu.rd(a, d);
    chk(d, exp);
  endtask : rchk
  // Bounded wait; running out ends the run
  task automatic waitv(ref logic s, input logic v, input int n);
    for (int i = 0; i < n; i++) begin
      if (s === v) break;
      @(posedge clk_sys);
      #1;
    end
    chk({7'h00, s}, {7'h00, v});
    if (s !== v) close_out();
  endtask : waitv
  // Free-running system clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Main sequence
  initial begin
    srst = 1'b1;
    standbyReq = 1'b0;
    nmiReq = 1'b0;
    repeat (2) @(posedge clk_sys);
    srst <= 1'b0;
    rchk(8'hb8, 8'h18);
    rchk(8'hb9, 8'h00);
    rchk(8'hbb, 8'h1f);
    // Byte write and wrong key both ignored
    u_cpu.wr(8'hb8, 16'ha5e7, 1'b0);
    u_cpu.wr(8'hb8, 16'h3ce7, 1'b1);
    rchk(8'hb8, 8'h18);
    // Slowest prescale leaves the loaded value in place
    u_cpu.wr(8'hb8, 16'ha527, 1'b1);
    u_cpu.wr(8'hb8, 16'h5a42, 1'b1);
    rchk(8'hb9, 8'h42);
    rchk(8'hb8, 8'h3f);
    @(posedge clk_sys) standbyReq <= 1'b1;
    @(posedge clk_sys) standbyReq <= 1'b0;
    #1 chk({6'h00, standbyActive, standbyRefused}, 8'h01);
    u_cpu.wr(8'hb8, 16'ha500, 1'b1);
    rchk(8'hb9, 8'h00);
    u_cpu.wr(8'hb8, 16'ha520, 1'b1);
    waitv(intervalTimerIrq, 1'b1, 600);
    chk({7'h00, overflowOutN}, 8'h01);
    rchk(8'hb8, 8'hb8);
    u_cpu.wr(8'hb8, 16'ha500, 1'b1);
    rchk(8'hb8, 8'h18);
    u_cpu.wr(8'hba, 16'h5a60, 1'b1);
    rchk(8'hbb, 8'h7f);
    u_cpu.wr(8'hb8, 16'ha5e0, 1'b1);
    u_cpu.wr(8'hb8, 16'h5afe, 1'b1);
    waitv(chipRstOut, 1'b1, 20);
    chk({7'h00, chipRstManual}, 8'h01);
    rchk(8'hbb, 8'hff);
    rchk(8'hb8, 8'h18);
    waitv(chipRstOut, 1'b0, 600);
    u_cpu.wr(8'hba, 16'ha500, 1'b1);
    rchk(8'hbb, 8'h7f);
    // No chip reset: only counter and control clear
    u_cpu.wr(8'hba, 16'h5a00, 1'b1);
    u_cpu.wr(8'hb8, 16'ha5e0, 1'b1);
    u_cpu.wr(8'hb8, 16'h5afe, 1'b1);
    waitv(overflowOutN, 1'b0, 20);
    chk({7'h00, chipRstOut}, 8'h00);
    rchk(8'hb8, 8'h18);
    rchk(8'hb9, 8'h00);
    rchk(8'hbb, 8'h9f);
    // Let the low pulse run out so a pin reset cannot cut it short
    waitv(overflowOutN, 1'b1, 200);
    u_cpu.pin_rst();
    rchk(8'hbb, 8'h1f);
    // prescale 0 still covers settling here
    @(posedge clk_sys) standbyReq <= 1'b1;
    @(posedge clk_sys) standbyReq <= 1'b0;
    #1 chk({6'h00, standbyActive, chipClockEn}, 8'h02);
    @(posedge clk_sys) nmiReq <= 1'b1;
    @(posedge clk_sys) nmiReq <= 1'b0;
    waitv(chipClockEn, 1'b1, 600);
    chk({7'h00, standbyActive}, 8'h00);
    close_out();
  end
endmodule : tb
